// *** rsb_loader.sv ***
`timescale 1ns/1ps
module rsb_loader #(
	parameter int PLL_LOCK_CYC = rsb_pkg::PLL_LOCK_CYCLES
) (
	// clock and system reset
	input  wire logic                  sys_clk,
	input  wire logic                  rst,
	// chip reset pin, strap bus sampled in reset, live chip-mode pins
	input  wire logic                  chipResetPinN,
	input  wire logic [27:0]           addrPin,
	input  wire logic                  pll_test_mode_n,
	input  wire logic                  selftest_mode_n,
	input  wire logic                  scan_mode_n,
	// apb slave
	input  wire rsb_pkg::rsb_apb_req_t apbReq,
	output rsb_pkg::rsb_apb_rsp_t      apbRsp,
	// configuration and reset state
	output rsb_pkg::rsb_cfg_t          cfgOut,
	output logic                       bus_error_flag,
	output logic                       reset_state_out,
	// shared test port
	input  wire rsb_pkg::rsb_jtag_t    jtagPin,
	input  wire logic                  scanTdo,
	input  wire logic                  debugTdo,
	output logic                       tdoOut,
	output logic                       tdoOe,
	output rsb_pkg::rsb_jtag_t         scanTap,
	output rsb_pkg::rsb_jtag_t         debugTap
);
	import rsb_pkg::*;

	localparam int PIN_W = ADDR_W + 4 + 4;

	// ----------------------------------------
	// pin synchroniser
	// ----------------------------------------
	logic [PIN_W-1:0] pinRaw;
	logic [PIN_W-1:0] syncA_ff;
	logic [PIN_W-1:0] syncB_ff;
	logic [PIN_W-1:0] syncC_ff;
	logic [PIN_W-1:0] pinFilt_ff;
	logic [PIN_W-1:0] nxt_pinFilt;

	assign pinRaw = {jtagPin, chipResetPinN, pll_test_mode_n,
	                 selftest_mode_n, scan_mode_n, addrPin};

	// a bit only moves once the second and third stages agree
	assign nxt_pinFilt = (~(syncB_ff ^ syncC_ff) & syncC_ff)
	                   | ((syncB_ff ^ syncC_ff) & pinFilt_ff);

	always_ff @(posedge sys_clk) begin
		syncA_ff <= pinRaw;
		syncB_ff <= syncA_ff;
		syncC_ff <= syncB_ff;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pinFilt_ff <= {PIN_W{1'b1}};
		end else begin
			pinFilt_ff <= nxt_pinFilt;
		end
	end

	logic [ADDR_W-1:0] addrSync;
	logic [2:0]        modeSync;
	logic              chipResetN;
	rsb_jtag_t         jtagSync;

	assign addrSync   = pinFilt_ff[ADDR_W-1:0];
	assign modeSync   = pinFilt_ff[ADDR_W+2:ADDR_W];
	assign chipResetN = pinFilt_ff[ADDR_W+3];
	assign jtagSync   = pinFilt_ff[PIN_W-1:ADDR_W+4];

	// ----------------------------------------
	// strap capture
	// ----------------------------------------
	logic              inReset;
	logic              inReset_ff;
	logic              releaseEdge;
	logic [ADDR_W-1:0] strap_ff;
	logic [ADDR_W-1:0] rstStrap;

	assign inReset     = ~chipResetN;
	assign releaseEdge = inReset_ff & ~inReset;

	// default straps line up with the field positions
	assign rstStrap = ADDR_W'({1'b0, 1'b0, 1'b0, RST_BOOTCS, 3'h0, RST_IDENT,
	                           RST_ISCALE, RST_FSEL, RST_FBDIV});

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			inReset_ff <= 1'b0;
		end else begin
			inReset_ff <= inReset;
		end
	end

	// follows the bus while chip reset is low, frozen once released
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			strap_ff <= rstStrap;
		end else if (inReset) begin
			strap_ff <= addrSync;
		end
	end

	// ----------------------------------------
	// field decode
	// ----------------------------------------
	rsb_cfg_t  nxt_cfg;
	rsb_cfg_t  cfg_ff;
	logic [1:0] csCode;
	logic [1:0] csWidth;

	assign csCode  = strap_ff[POS_BOOTCS_LO +: 2];
	// code 10 is treated as 32-bit like 01
	assign csWidth = (csCode == 2'h0) ? WID_8 :
	                 (csCode == 2'h3) ? WID_16 : WID_32;

	assign nxt_cfg.bigEndian        = strap_ff[POS_ENDIAN];
	assign nxt_cfg.cpuEnable        = strap_ff[POS_CPU_EN];
	assign nxt_cfg.bootChipSelect   = csCode;
	assign nxt_cfg.bootPortWidth    = csWidth;
	assign nxt_cfg.bootWaitStates   = BOOT_WAITS;
	assign nxt_cfg.systemIdentField = strap_ff[POS_IDENT_LO +: 11];
	assign nxt_cfg.pllInputScale    = strap_ff[POS_ISCALE_LO +: 2];
	assign nxt_cfg.pllFreqSelect    = strap_ff[POS_FSEL_LO +: 2];
	assign nxt_cfg.pllFeedbackDiv   = strap_ff[POS_FBDIV_LO +: 5];

	rsb_cfg_t rstCfg;

	assign rstCfg.bigEndian        = 1'b0;
	assign rstCfg.cpuEnable        = 1'b0;
	assign rstCfg.bootChipSelect   = RST_BOOTCS;
	assign rstCfg.bootPortWidth    = WID_8;
	assign rstCfg.bootWaitStates   = BOOT_WAITS;
	assign rstCfg.systemIdentField = RST_IDENT;
	assign rstCfg.pllInputScale    = RST_ISCALE;
	assign rstCfg.pllFreqSelect    = RST_FSEL;
	assign rstCfg.pllFeedbackDiv   = RST_FBDIV;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cfg_ff <= rstCfg;
		end else begin
			cfg_ff <= nxt_cfg;
		end
	end

	assign cfgOut = cfg_ff;

	// ----------------------------------------
	// control register and bus error flag
	// ----------------------------------------
	logic pllEnable_ff;
	logic busErr_ff;
	logic nxt_busErr;
	logic busErrSet;
	logic busErrClr;
	logic wrDone;
	logic selStrap;
	logic selStatus;
	logic selCtrl;

	assign busErrSet  = releaseEdge & ~strap_ff[POS_CPU_EN];
	assign busErrClr  = wrDone & selStatus & apbReq.pwdata[STS_BUSERR];
	// a fresh strap-time event beats a software clear in the same cycle
	assign nxt_busErr = busErrSet | (busErr_ff & ~busErrClr);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			busErr_ff <= 1'b0;
		end else if (releaseEdge & strap_ff[POS_CPU_EN]) begin
			busErr_ff <= 1'b0;
		end else begin
			busErr_ff <= nxt_busErr;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pllEnable_ff <= RST_PLLEN;
		end else if (wrDone & selCtrl) begin
			pllEnable_ff <= apbReq.pwdata[CTL_PLLEN];
		end
	end

	assign bus_error_flag = busErr_ff;

	// ----------------------------------------
	// reset-state hold
	// ----------------------------------------
	logic [HOLD_W-1:0] hold_ff;
	logic [HOLD_W-1:0] holdLoad;
	logic              rstState_ff;

	assign holdLoad = pllEnable_ff ? HOLD_W'(PLL_LOCK_CYC) : HOLD_W'(HOLD_NOPLL_CYC);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			hold_ff     <= HOLD_W'(HOLD_NOPLL_CYC);
			rstState_ff <= 1'b1;
		end else if (inReset) begin
			hold_ff     <= holdLoad;
			rstState_ff <= 1'b1;
		end else if (hold_ff != '0) begin
			hold_ff     <= hold_ff - HOLD_W'(1);
			rstState_ff <= 1'b1;
		end else begin
			rstState_ff <= 1'b0;
		end
	end

	assign reset_state_out = rstState_ff;

	// ----------------------------------------
	// test port steering
	// ----------------------------------------
	logic      debugMode;
	logic      debugSel_ff;
	logic      tdo_ff;
	rsb_jtag_t scanTap_ff;
	rsb_jtag_t debugTap_ff;
	rsb_jtag_t idleTap;

	assign debugMode = (modeSync == DEBUG_MODE_CODE);
	// an unselected tap sees reset held and tms high
	assign idleTap   = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trstN: 1'b0};

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			debugSel_ff <= 1'b0;
			scanTap_ff  <= idleTap;
			debugTap_ff <= idleTap;
			tdo_ff      <= 1'b0;
		end else begin
			debugSel_ff <= debugMode;
			scanTap_ff  <= debugMode ? idleTap : jtagSync;
			debugTap_ff <= debugMode ? jtagSync : idleTap;
			tdo_ff      <= debugSel_ff ? debugTdo : scanTdo;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			tdoOe <= 1'b0;
		end else begin
			tdoOe <= jtagSync.trstN;
		end
	end

	assign tdoOut   = tdo_ff;
	assign scanTap  = scanTap_ff;
	assign debugTap = debugTap_ff;

	// ----------------------------------------
	// apb slave
	// ----------------------------------------
	logic         access;
	logic         mapped;
	logic [31:0]  rdMux;
	logic [31:0]  statusWord;
	rsb_apb_rsp_t rsp_ff;

	assign access    = apbReq.psel & apbReq.penable;
	assign wrDone    = access & rsp_ff.pready & apbReq.pwrite;
	assign selStrap  = (apbReq.paddr == OFF_STRAP);
	assign selStatus = (apbReq.paddr == OFF_STATUS);
	assign selCtrl   = (apbReq.paddr == OFF_CTRL);
	assign mapped    = selStrap | selStatus | selCtrl;

	assign statusWord = {29'h0, debugSel_ff, rstState_ff, busErr_ff};

	assign rdMux = selStrap  ? {4'h0, strap_ff} :
	               selStatus ? statusWord :
	               selCtrl   ? {31'h0, pllEnable_ff} : 32'h0;

	// one wait state: pready rises in the second access cycle
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rsp_ff <= '0;
		end else if (access & ~rsp_ff.pready) begin
			rsp_ff.pready  <= 1'b1;
			rsp_ff.pslverr <= ~mapped | (apbReq.pwrite & selStrap);
			rsp_ff.prdata  <= apbReq.pwrite ? 32'h0 : rdMux;
		end else begin
			rsp_ff <= '0;
		end
	end

	assign apbRsp = rsp_ff;

endmodule

// *** rsb_loader_assertions.sv ***
`timescale 1ns/1ps
module rsb_assertions #(
	parameter int PLL_LOCK_CYC = rsb_pkg::PLL_LOCK_CYCLES
) (
	// clock and reset
	input wire logic               sys_clk,
	input wire logic               rst,
	// pins
	input wire logic               chipResetPinN,
	input wire logic [27:0]        addrPin,
	input wire logic               pll_test_mode_n,
	input wire logic               selftest_mode_n,
	input wire logic               scan_mode_n,
	input wire rsb_pkg::rsb_jtag_t jtagPin,
	// register bus
	input wire rsb_pkg::rsb_apb_req_t apbReq,
	input wire rsb_pkg::rsb_apb_rsp_t apbRsp,
	// results
	input wire rsb_pkg::rsb_cfg_t  cfgOut,
	input wire logic               bus_error_flag,
	input wire logic               reset_state_out,
	input wire rsb_pkg::rsb_jtag_t scanTap,
	input wire rsb_pkg::rsb_jtag_t debugTap
);
	import rsb_pkg::*;
	localparam rsb_jtag_t IDLE = 4'h6;
	logic [2:0] mode;
	logic [1:0] expWidth;
	logic [HOLD_W-1:0] hiCnt_ff;
	logic [HOLD_W-1:0] nxt_hiCnt;
	logic              pllEn_ff;
	int                holdExp_ff;
	assign mode = {pll_test_mode_n, selftest_mode_n, scan_mode_n};
	assign expWidth = addrPin[24:23] == 2'h0 ? WID_8 : addrPin[24:23] == 2'h3 ? WID_16 : WID_32;
	// cycles spent in the reset-state hold after the pin let go
	assign nxt_hiCnt = (reset_state_out && chipResetPinN) ? hiCnt_ff + HOLD_W'(1) : '0;
	always_ff @(posedge sys_clk) begin
		hiCnt_ff <= rst ? '0 : nxt_hiCnt;
	end
	// hold length picked by the pll enable bit while the chip reset pin is low
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pllEn_ff   <= RST_PLLEN;
			holdExp_ff <= HOLD_NOPLL_CYC;
		end else begin
			if (apbReq.psel && apbReq.penable && apbRsp.pready && apbReq.pwrite && apbReq.paddr == OFF_CTRL) begin
				pllEn_ff <= apbReq.pwdata[CTL_PLLEN];
			end
			if (!chipResetPinN) begin
				holdExp_ff <= pllEn_ff ? PLL_LOCK_CYC : HOLD_NOPLL_CYC;
			end
		end
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence s_strap;
		(!chipResetPinN && $stable(addrPin)) [*8];
	endsequence
	property p_endian; s_strap |-> cfgOut.bigEndian == addrPin[27]; endproperty
	property p_cpu; s_strap |-> cfgOut.cpuEnable == addrPin[26]; endproperty
	property p_buserr;
		!chipResetPinN [*3] ##1 chipResetPinN |-> ##7 bus_error_flag == !$past(addrPin[26], 8);
	endproperty
	property p_bootcs;
		s_strap |-> cfgOut.bootChipSelect == addrPin[24:23] && cfgOut.bootPortWidth == expWidth
			&& cfgOut.bootWaitStates == BOOT_WAITS;
	endproperty
	property p_ident; s_strap |-> cfgOut.systemIdentField == addrPin[19:9]; endproperty
	property p_iscale; s_strap |-> cfgOut.pllInputScale == addrPin[8:7]; endproperty
	property p_fsel; s_strap |-> cfgOut.pllFreqSelect == addrPin[6:5]; endproperty
	property p_fbdiv; s_strap |-> cfgOut.pllFeedbackDiv == addrPin[4:0]; endproperty
	property p_frozen; chipResetPinN [*8] |=> $stable(cfgOut); endproperty
	property p_in_reset; !chipResetPinN [*6] |-> reset_state_out; endproperty
	property p_hold;
		$fell(reset_state_out) |-> int'(hiCnt_ff) >= holdExp_ff && int'(hiCnt_ff) <= holdExp_ff + 8;
	endproperty
	property p_scan; (mode != DEBUG_MODE_CODE && $stable(jtagPin)) [*8] |-> scanTap == jtagPin && debugTap == IDLE;
	endproperty
	property p_debug; (mode == DEBUG_MODE_CODE && $stable(jtagPin)) [*8] |-> debugTap == jtagPin && scanTap == IDLE;
	endproperty
	a_endian: assert property (p_endian) else $error("endian strap not loaded");
	a_cpu: assert property (p_cpu) else $error("cpu enable strap not loaded");
	a_buserr: assert property (p_buserr) else $error("bus error flag wrong after release");
	a_bootcs: assert property (p_bootcs) else $error("boot chip select wrong");
	a_ident: assert property (p_ident) else $error("ident strap not loaded");
	a_iscale: assert property (p_iscale) else $error("input scale strap not loaded");
	a_fsel: assert property (p_fsel) else $error("freq select strap not loaded");
	a_fbdiv: assert property (p_fbdiv) else $error("feedback divider strap not loaded");
	a_frozen: assert property (p_frozen) else $error("config moved after release");
	a_in_reset: assert property (p_in_reset) else $error("reset state low in reset");
	a_hold: assert property (p_hold) else $error("reset state hold length wrong");
	a_scan: assert property (p_scan) else $error("scan tap not connected");
	a_debug: assert property (p_debug) else $error("debug tap not connected");
	c_strap: cover property (s_strap);
	c_hold: cover property ($fell(reset_state_out));
	c_debug: cover property ((mode == DEBUG_MODE_CODE) [*8]);
endmodule

bind rsb_loader rsb_assertions #(.PLL_LOCK_CYC(PLL_LOCK_CYC)) rsb_assertions_i (.sys_clk, .rst, .chipResetPinN,
	.addrPin, .pll_test_mode_n, .selftest_mode_n, .scan_mode_n, .jtagPin, .apbReq, .apbRsp, .cfgOut, .bus_error_flag,
	.reset_state_out, .scanTap, .debugTap);

// *** rsb_pkg.sv ***
// Overview of operation
// - straps load configuration while chip reset held
// - address 27 low little, high big endian
// - address 26 enables core, else bus-error flag
// - address 24:23 sets boot chip-select memory mode
// - address 19:9 loads system ident, default 3ff
// - address 8:7 loads pll input scale, default 10
// - address 6:5 loads pll freq select, default 00
// - address 4:0 loads pll feedback divider
// - boundary scan reaches every pin through test port
// - core debug only under debug chip-mode pins
// - chip-mode pins pick which tap owns pins
// - reset pin passes three-stage synchroniser
// - reset-state output held 512 cycles or lock time
package rsb_pkg;

	// ----------------------------------------
	// strap positions on the address bus
	// ----------------------------------------
	localparam int ADDR_W        = 28;
	localparam int POS_ENDIAN    = 27;
	localparam int POS_CPU_EN    = 26;
	localparam int POS_BOOTCS_LO = 23;
	localparam int POS_IDENT_LO  = 9;
	localparam int POS_ISCALE_LO = 7;
	localparam int POS_FSEL_LO   = 5;
	localparam int POS_FBDIV_LO  = 0;

	// ----------------------------------------
	// values after reset
	// ----------------------------------------
	localparam logic [10:0] RST_IDENT  = 11'h3ff;
	localparam logic [1:0]  RST_ISCALE = 2'h2;
	localparam logic [1:0]  RST_FSEL   = 2'h0;
	localparam logic [4:0]  RST_FBDIV  = 5'h0b;
	localparam logic [1:0]  RST_BOOTCS = 2'h0;
	localparam logic [5:0]  BOOT_WAITS = 6'h3f;

	// boot chip-select port width codes
	localparam logic [1:0] WID_8  = 2'h0;
	localparam logic [1:0] WID_16 = 2'h1;
	localparam logic [1:0] WID_32 = 2'h2;

	// chip-mode pin code {pll_test_mode_n, selftest_mode_n, scan_mode_n} that opens core debug
	localparam logic [2:0] DEBUG_MODE_CODE = 3'h3;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_PS   = 8000;
	localparam int PLL_LOCK_NS     = 100000;
	localparam int PLL_LOCK_CYCLES = PLL_LOCK_NS * 1000 / CLK_PERIOD_PS;
	localparam int HOLD_NOPLL_CYC  = 512;
	localparam int HOLD_W          = 24;

	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] OFF_STRAP  = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_CTRL   = 8'h08;
	localparam int STS_BUSERR  = 0;
	localparam int STS_RSTSTAT = 1;
	localparam int STS_DEBUG   = 2;
	localparam int CTL_PLLEN   = 0;
	localparam logic RST_PLLEN = 1'b1;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} rsb_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} rsb_apb_rsp_t;

	typedef struct packed {
		logic        bigEndian;
		logic        cpuEnable;
		logic [1:0]  bootChipSelect;
		logic [1:0]  bootPortWidth;
		logic [5:0]  bootWaitStates;
		logic [10:0] systemIdentField;
		logic [1:0]  pllInputScale;
		logic [1:0]  pllFreqSelect;
		logic [4:0]  pllFeedbackDiv;
	} rsb_cfg_t;

	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
		logic trstN;
	} rsb_jtag_t;

endpackage

// *** rsb_strap_board.sv ***
`timescale 1ns/1ps
module rsb_strap_board (
	// clock and chip reset pin
	input  wire logic        sys_clk,
	input  wire logic        chipResetPinN,
	// resistor values
	input  wire logic [27:0] strap,
	// address bus
	output logic [27:0]      addrPin
);
	logic [27:0] busCnt_ff = '0;
	always @(posedge sys_clk) begin
		busCnt_ff <= busCnt_ff + 28'h1;
	end
	// straps only show while reset is held, otherwise live bus traffic
	assign addrPin = chipResetPinN ? ~strap ^ busCnt_ff : strap;
endmodule

// *** tb_reset_strap_bootstrap_loader.sv ***
`timescale 1ns/1ps
module tb_reset_strap_bootstrap_loader;
	import rsb_pkg::*;
	localparam int        LOCK = 20;
	localparam rsb_jtag_t IDLE = 4'h6;
	logic         sys_clk = 0;
	logic         rst = 1;
	logic         chipResetPinN = 1;
	logic [27:0]  strap = '0;
	logic [27:0]  addrPin;
	logic         pll_test_mode_n = 1, selftest_mode_n = 1, scan_mode_n = 1;
	logic         scanTdo = 0, debugTdo = 0, tdoOut, tdoOe, bus_error_flag, reset_state_out, err, dbg;
	rsb_apb_req_t apbReq = '0;
	rsb_apb_rsp_t apbRsp;
	rsb_cfg_t     cfgOut;
	rsb_jtag_t    jtagPin = '0, scanTap, debugTap;
	logic [31:0]  rd;
	int           n_fail = 0, comparisons = 0;

	rsb_loader #(.PLL_LOCK_CYC(LOCK)) rsb_loader_i (.sys_clk, .rst, .chipResetPinN, .addrPin, .pll_test_mode_n,
		.selftest_mode_n, .scan_mode_n, .apbReq, .apbRsp, .cfgOut, .bus_error_flag, .reset_state_out, .jtagPin,
		.scanTdo, .debugTdo, .tdoOut, .tdoOe, .scanTap, .debugTap);
	rsb_strap_board rsb_strap_board_i (.sys_clk, .chipResetPinN, .strap, .addrPin);

	always #4 sys_clk = ~sys_clk;

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task results;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
		apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
		@(posedge sys_clk);
		apbReq.penable <= 1'b1;
		do @(posedge sys_clk); while (apbRsp.pready !== 1'b1);
		rd = apbRsp.prdata;
		err = apbRsp.pslverr;
		apbReq <= '0;
		@(posedge sys_clk);
	endtask

	task pulse(input logic [27:0] s);
		strap <= s;
		chipResetPinN <= 1'b0;
		repeat (10) @(posedge sys_clk);
		chipResetPinN <= 1'b1;
		repeat (12) @(posedge sys_clk);
	endtask

	function automatic rsb_cfg_t expCfg(input logic [27:0] s);
		logic [1:0] w;
		w = s[24:23] == 2'h0 ? WID_8 : s[24:23] == 2'h3 ? WID_16 : WID_32;
		return {s[27], s[26], s[24:23], w, BOOT_WAITS, s[19:9], s[8:7], s[6:5], s[4:0]};
	endfunction

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_straps;
		logic [27:0] tbl [4];
		tbl = '{28'h0000000, 28'h4812345, 28'h9000abc, 28'hfffffff};
		foreach (tbl[i]) begin
			pulse(tbl[i]);
			chk(cfgOut, expCfg(tbl[i]));
			chk(bus_error_flag, !tbl[i][26]);
			apb(1'b0, OFF_STRAP, 32'h0);
			chk(rd, {4'h0, tbl[i]});
			chk(cfgOut, expCfg(tbl[i]));
		end
	endtask

	task t_status;
		pulse(28'h0);
		apb(1'b0, OFF_STATUS, 32'h0);
		chk(rd[0], 1'b1);
		apb(1'b1, OFF_STATUS, 32'h1);
		apb(1'b0, OFF_STATUS, 32'h0);
		chk(rd[0], 1'b0);
		apb(1'b1, OFF_STRAP, 32'hffffffff);
		chk(err, 1'b1);
		apb(1'b0, OFF_STRAP, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
	endtask

	task t_hold;
		int n;
		for (int p = 0; p < 2; p++) begin
			apb(1'b1, OFF_CTRL, p);
			strap <= 28'h0;
			chipResetPinN <= 1'b0;
			repeat (10) @(posedge sys_clk);
			chipResetPinN <= 1'b1;
			n = 0;
			do begin
				@(posedge sys_clk);
				n++;
			end while (reset_state_out === 1'b1 && n < 2000);
			n = n - (p ? LOCK : HOLD_NOPLL_CYC);
			chk(n >= 2 && n <= 8, 1'b1);
			apb(1'b0, OFF_STATUS, 32'h0);
			chk(rd[1], 1'b0);
		end
	endtask

	// a one-cycle dip on the chip reset pin must be ignored
	task t_glitch;
		strap <= 28'hfffffff;
		chipResetPinN <= 1'b0;
		@(posedge sys_clk);
		chipResetPinN <= 1'b1;
		repeat (12) @(posedge sys_clk);
		chk(cfgOut, expCfg(28'h0));
		chk(reset_state_out, 1'b0);
	endtask

	task t_jtag;
		for (int m = 0; m < 8; m++) begin
			{pll_test_mode_n, selftest_mode_n, scan_mode_n} <= m[2:0];
			jtagPin <= rsb_jtag_t'(m[3:0] ^ 4'hc);
			scanTdo <= ~m[0];
			debugTdo <= m[0];
			repeat (10) @(posedge sys_clk);
			dbg = m[2:0] == DEBUG_MODE_CODE;
			chk(debugTap, dbg ? jtagPin : IDLE);
			chk(scanTap, dbg ? IDLE : jtagPin);
			chk(tdoOe, jtagPin.trstN);
			if (jtagPin.trstN) chk(tdoOut, dbg ? debugTdo : scanTdo);
			apb(1'b0, OFF_STATUS, 32'h0);
			chk(rd[2], dbg);
		end
	endtask

	initial begin
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		chk(cfgOut, {2'h0, RST_BOOTCS, WID_8, BOOT_WAITS, RST_IDENT, RST_ISCALE, RST_FSEL, RST_FBDIV});
		apb(1'b0, OFF_CTRL, 32'h0);
		chk(rd, 32'h1);
		t_straps();
		t_status();
		t_hold();
		t_glitch();
		t_jtag();
		results();
	end

	initial begin
		repeat (20000) @(posedge sys_clk);
		n_fail++;
		results();
	end
endmodule
